// file: hw/genset_customer_io_logic.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
// Notes on behaviour
// [RL1] Auto plus remote start grounded starts cranking
// [RL2] Shutdown reset ignored while remote start grounded
// [RL3] Low fuel wakes then warns
// [RL4] Four customer faults: warning or shutdown
// [RL5] Per-fault editable message shown when grounded
// [RL6] Faults two and three wake controller
// [RL7] Auto, start open: reset clears except estop
// [RL8] Emergency stop shuts down, panel reset only
// [RL9] Manual run idle: no buildup, 800 RPM
// [RL10] Idle released: normal speed and voltage
// [RL11] Idle refused in automatic mode
// [RL12] Idle uses lower oil pressure thresholds
// [RL13] Leaving idle restores normal oil thresholds
// [RL14] Shutdown latches breaker trip until reset
// [RL15] Common alarm on any warning or shutdown
// [RL16] Load dump after five seconds persistence
// [RL17] Load dump energised before resulting shutdown
// [RL18] Ready-to-load above ninety percent nominal
// [RL19] Switched supply follows governor run pilot
// [RL20] Faults default warning; saved choice retained
// [RL21] Contact inputs synchronised and debounced
// [RL22] Load dump timer restarts when conditions clear
module genset_customer_io_logic
    import custio_pkg::*;
#(
    parameter logic [31:0] LOAD_DUMP_CYCLES = custio_pkg::LOAD_DUMP_CYC
)
(
    input wire logic mclk, // 250 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic remoteStart_b, // Grounded = start
    input wire logic lowFuel_b, // Grounded = low fuel
    input wire logic [3:0] custFault_b, // Grounded = fault
    input wire logic faultReset_b, // Grounded = reset
    input wire logic engineIdle_b, // Grounded = idle
    input wire logic eStop_b, // Grounded = emergency stop
    input wire logic overload, // Overload condition
    input wire logic underFreq, // Underfrequency condition
    input wire logic [15:0] measVolts, // Measured output volts
    input wire logic [15:0] measFreq, // Measured frequency
    input wire logic runPilot, // Governor run pilot
    input wire logic [15:0] oilPressure, // Measured oil pressure
    output logic crankStart, // Start sequence request
    output logic wake, // Wake dormant controller
    output logic breakerTrip, // Breaker trip relay
    output logic commonAlarm, // Common alarm relay
    output logic loadDump, // Load dump relay
    output logic readyToLoad, // Ready-to-load relay
    output logic switchedSupply, // Switched B+ output
    output logic inhibitBuildup, // Voltage build-up inhibit
    output logic [11:0] speedTarget, // Governor target RPM
    output logic [2:0] msgSel, // Message shown, 0 none
    output logic shutdown, // Any shutdown latched
    input wire logic [7:0] s_axi_awaddr, // AXI write address
    input wire logic s_axi_awvalid, // AXI
    output logic s_axi_awready, // AXI
    input wire logic [31:0] s_axi_wdata, // AXI
    input wire logic [3:0] s_axi_wstrb, // AXI
    input wire logic s_axi_wvalid, // AXI
    output logic s_axi_wready, // AXI
    output logic [1:0] s_axi_bresp, // AXI
    output logic s_axi_bvalid, // AXI
    input wire logic s_axi_bready, // AXI
    input wire logic [7:0] s_axi_araddr, // AXI
    input wire logic s_axi_arvalid, // AXI
    output logic s_axi_arready, // AXI
    output logic [31:0] s_axi_rdata, // AXI
    output logic [1:0] s_axi_rresp, // AXI
    output logic s_axi_rvalid, // AXI
    input wire logic s_axi_rready // AXI
);
    import custio_pkg::*;

    // ------------------------------------------------------------
    // Input synchronise and debounce
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] rawIn;
    logic [NUM_IN-1:0] meta;
    logic [NUM_IN-1:0] syncd;
    logic [NUM_IN-1:0] clean;
    assign rawIn = {1'b1, eStop_b, engineIdle_b, faultReset_b,
                    custFault_b, lowFuel_b, remoteStart_b};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++)
        begin : g_db
            logic [DB_W-1:0] cnt;
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta[gi] <= 1'b0;
                    syncd[gi] <= 1'b0;
                end
                else
                begin
                    meta[gi] <= ~rawIn[gi]; // RL21
                    syncd[gi] <= meta[gi];
                end
            end
            // Contact must hold steady for the whole window to count
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    cnt <= '0;
                    clean[gi] <= 1'b0;
                end
                else if (syncd[gi] == clean[gi])
                    cnt <= '0;
                else if (cnt == DB_W'(DEBOUNCE_CYC - 1))
                begin
                    cnt <= '0;
                    clean[gi] <= syncd[gi]; // RL21
                end
                else
                    cnt <= cnt + 1'b1;
            end
        end
    endgenerate

    logic rStart, lFuel, fReset, idleIn, eStop;
    logic [3:0] cFault;
    assign rStart = clean[IN_RSTART];
    assign lFuel = clean[IN_LOWFUEL];
    assign cFault = clean[IN_CF0 +: NUM_CF];
    assign fReset = clean[IN_FRESET];
    assign idleIn = clean[IN_IDLE];
    assign eStop = clean[IN_ESTOP];

    // ------------------------------------------------------------
    // Software-visible configuration
    // ------------------------------------------------------------
    logic modeAuto, modeRun, panelReset;
    logic [3:0] cfgShtd, cfgEdit;
    logic [31:0] nominal, oilNorm, oilIdle;
    logic [11:0] normalRpm;
    logic [31:0] msgMem [NUM_CF];

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    logic fResetPrev, resetEdge, resetOk;
    logic warnFuel, estopLatch, oilWarn, oilShtd;
    logic [3:0] cfWarn, cfShtd;
    logic ldShtd, anyShtd, anyWarn;
    logic idleActive;
    logic [15:0] oilWarnLim, oilShtdLim;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fResetPrev <= 1'b0;
        else
            fResetPrev <= fReset;
    end
    assign resetEdge = fReset & ~fResetPrev;
    // Remote reset only in auto with start contact open
    assign resetOk = resetEdge & modeAuto & ~rStart; // RL2 RL7

    // Set wins over clear in each latch below
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            warnFuel <= 1'b0;
            cfWarn <= 4'h0;
            cfShtd <= 4'h0;
            oilWarn <= 1'b0;
            oilShtd <= 1'b0;
            ldShtd <= 1'b0;
        end
        else
        begin
            warnFuel <= lFuel | (warnFuel & ~resetOk); // RL3 RL7
            cfWarn <= (cFault & ~cfgShtd)
                    | (cfWarn & {4{~resetOk}}); // RL4
            cfShtd <= (cFault & cfgShtd)
                    | (cfShtd & {4{~resetOk}}); // RL4 RL2
            oilWarn <= (oilPressure < oilWarnLim) & runPilot
                     | (oilWarn & ~resetOk);
            oilShtd <= (oilPressure < oilShtdLim) & runPilot
                     | (oilShtd & ~resetOk);
            // Dump relay closes first; shutdown follows a cycle later
            ldShtd <= loadDump | (ldShtd & ~resetOk); // RL17
        end
    end

    // Emergency stop is cleared from the panel, never remotely
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            estopLatch <= 1'b0;
        else
            estopLatch <= eStop | (estopLatch & ~panelReset); // RL8
    end

    assign anyShtd = estopLatch | (|cfShtd) | oilShtd | ldShtd;
    assign anyWarn = warnFuel | (|cfWarn) | oilWarn;

    // ------------------------------------------------------------
    // Idle handling
    // ------------------------------------------------------------
    assign idleActive = idleIn & modeRun & ~modeAuto; // RL9 RL11
    assign oilWarnLim = idleActive ? oilIdle[15:0]
                                   : oilNorm[15:0]; // RL12 RL13
    assign oilShtdLim = idleActive ? oilIdle[31:16]
                                   : oilNorm[31:16]; // RL12 RL13

    // ------------------------------------------------------------
    // Load dump persistence
    // ------------------------------------------------------------
    logic [31:0] ldCnt;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ldCnt <= '0;
            loadDump <= 1'b0;
        end
        else if (!(overload | underFreq))
        begin
            ldCnt <= '0; // RL22
            loadDump <= 1'b0;
        end
        else if (ldCnt >= LOAD_DUMP_CYCLES - 1)
            loadDump <= 1'b1; // RL16
        else
            ldCnt <= ldCnt + 1;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [23:0] vLim, fLim;
    assign vLim = 24'(nominal[15:0]) * 24'(RTL_PCT);
    assign fLim = 24'(nominal[31:16]) * 24'(RTL_PCT);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crankStart <= 1'b0;
            wake <= 1'b0;
            breakerTrip <= 1'b0;
            commonAlarm <= 1'b0;
            readyToLoad <= 1'b0;
            switchedSupply <= 1'b0;
            inhibitBuildup <= 1'b0;
            speedTarget <= NORMAL_RPM_RST;
            shutdown <= 1'b0;
        end
        else
        begin
            crankStart <= modeAuto & rStart & ~anyShtd; // RL1
            wake <= lFuel | cFault[1] | cFault[2]; // RL3 RL6
            breakerTrip <= anyShtd; // RL14
            commonAlarm <= anyShtd | anyWarn; // RL15
            readyToLoad <= (24'(measVolts) * 24'd100 > vLim)
                         & (24'(measFreq) * 24'd100 > fLim); // RL18
            switchedSupply <= runPilot; // RL19
            inhibitBuildup <= idleActive; // RL9 RL10
            speedTarget <= idleActive ? IDLE_RPM
                                      : normalRpm; // RL9 RL10
            shutdown <= anyShtd;
        end
    end

    // Lowest active fault's message index
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            msgSel <= 3'd0;
        else if (cFault[0])
            msgSel <= 3'd1; // RL5
        else if (cFault[1])
            msgSel <= 3'd2;
        else if (cFault[2])
            msgSel <= 3'd3;
        else if (cFault[3])
            msgSel <= 3'd4;
        else
            msgSel <= 3'd0;
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic awHeld, wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr <= REG_MSG0 + 8'h0C)
                             ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (st[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction

    // Setup choice only takes effect on save; edits stay pending
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modeAuto <= 1'b0;
            modeRun <= 1'b0;
            panelReset <= 1'b0;
            cfgEdit <= CF_SHTD_RST;
            cfgShtd <= CF_SHTD_RST; // RL20
            nominal <= NOMINAL_RST;
            oilNorm <= OIL_RST;
            oilIdle <= OIL_RST;
            normalRpm <= NORMAL_RPM_RST;
        end
        else
        begin
            panelReset <= 1'b0;
            if (doWrite)
            begin
                unique case (awAddr)
                    REG_CTRL:
                    begin
                        modeAuto <= wData[CTRL_AUTO];
                        modeRun <= wData[CTRL_RUN];
                        panelReset <= wData[CTRL_PANEL_RST]; // RL8
                        if (wData[CTRL_SAVE])
                            cfgShtd <= cfgEdit; // RL20
                    end
                    REG_CFG: cfgEdit <= wData[3:0];
                    REG_NOMINAL: nominal <= merge(nominal, wData, wStrb);
                    REG_OILNORM: oilNorm <= merge(oilNorm, wData, wStrb);
                    REG_OILIDLE: oilIdle <= merge(oilIdle, wData, wStrb);
                    REG_RPM: normalRpm <= wData[11:0];
                    default: ;
                endcase
            end
        end
    end

    // Message store for the four customer faults
    always_ff @(posedge mclk)
    begin
        if (doWrite && awAddr[7:4] == REG_MSG0[7:4] && awAddr[1:0] == 2'b00)
            msgMem[awAddr[3:2]] <= merge(msgMem[awAddr[3:2]], wData,
                                         wStrb); // RL5
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {30'h0, modeRun, modeAuto};
                REG_STATUS: s_axi_rdata <= {16'h0, 3'h0, estopLatch,
                    ldShtd, oilShtd, oilWarn, warnFuel, cfShtd, cfWarn};
                REG_CFG: s_axi_rdata <= {24'h0, cfgShtd, cfgEdit};
                REG_NOMINAL: s_axi_rdata <= nominal;
                REG_OILNORM: s_axi_rdata <= oilNorm;
                REG_OILIDLE: s_axi_rdata <= oilIdle;
                REG_OILTRIP: s_axi_rdata <= {oilShtdLim, oilWarnLim};
                REG_RPM: s_axi_rdata <= {20'h0, normalRpm};
                REG_MSG0, REG_MSG0 + 8'h04, REG_MSG0 + 8'h08,
                REG_MSG0 + 8'h0C:
                    s_axi_rdata <= msgMem[s_axi_araddr[3:2]];
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = ~s_axi_rvalid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_estop_hold;
        @(posedge mclk) disable iff (!rst_b)
        estopLatch && !panelReset |=> estopLatch;
    endproperty
    a_estop_hold: assert property (p_estop_hold) // RL8
        else $error("estop cleared without panel reset");

    property p_trip;
        @(posedge mclk) disable iff (!rst_b)
        anyShtd |=> breakerTrip;
    endproperty
    a_trip: assert property (p_trip) // RL14
        else $error("breaker trip missing");

    property p_alarm;
        @(posedge mclk) disable iff (!rst_b)
        (anyWarn || anyShtd) |=> commonAlarm;
    endproperty
    a_alarm: assert property (p_alarm) // RL15
        else $error("common alarm missing");

    property p_idle_speed;
        @(posedge mclk) disable iff (!rst_b)
        idleActive |=> speedTarget == IDLE_RPM && inhibitBuildup;
    endproperty
    a_idle_speed: assert property (p_idle_speed) // RL9
        else $error("idle speed not applied");

    property p_no_idle_auto;
        @(posedge mclk) disable iff (!rst_b)
        modeAuto |-> !idleActive ##1 !inhibitBuildup;
    endproperty
    a_no_idle_auto: assert property (p_no_idle_auto) // RL11
        else $error("idle in auto");

    property p_dump_first;
        @(posedge mclk) disable iff (!rst_b)
        $rose(ldShtd) |-> $past(loadDump);
    endproperty
    a_dump_first: assert property (p_dump_first) // RL17
        else $error("shutdown before load dump");

    property p_dump_clear;
        @(posedge mclk) disable iff (!rst_b)
        !(overload || underFreq) |=> ldCnt == 0 && !loadDump;
    endproperty
    a_dump_clear: assert property (p_dump_clear) // RL22
        else $error("load dump timer not restarted");

    property p_start_block;
        @(posedge mclk) disable iff (!rst_b)
        rStart && cfShtd != 0 |=> cfShtd != 0;
    endproperty
    a_start_block: assert property (p_start_block) // RL2
        else $error("shutdown reset while start grounded");

    property p_pilot;
        @(posedge mclk) disable iff (!rst_b)
        runPilot |=> switchedSupply;
    endproperty
    a_pilot: assert property (p_pilot) // RL19
        else $error("switched supply not following pilot");
endmodule
`default_nettype wire

// file: inc/custio_pkg.sv
`default_nettype none
package custio_pkg;
    // ------------------------------------------------------------
    // Clock, timing and sizes
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int LOAD_DUMP_S = 5;
    localparam longint LOAD_DUMP_CYC_L = 64'(LOAD_DUMP_S) * 250_000_000;
    localparam logic [31:0] LOAD_DUMP_CYC = 32'(LOAD_DUMP_CYC_L);
    localparam int DB_W = 12;
    localparam int NUM_IN = 10;
    localparam int NUM_CF = 4;
    // Speed targets in RPM
    localparam logic [11:0] IDLE_RPM = 12'd800;
    // Ready-to-load threshold in percent of nominal
    localparam int RTL_PCT = 90;
    // ------------------------------------------------------------
    // AXI4-Lite register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_NOMINAL = 8'h0C;
    localparam logic [7:0] REG_OILNORM = 8'h10;
    localparam logic [7:0] REG_OILIDLE = 8'h14;
    localparam logic [7:0] REG_OILTRIP = 8'h18;
    localparam logic [7:0] REG_RPM = 8'h1C;
    localparam logic [7:0] REG_MSG0 = 8'h20;
    // CTRL field positions
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_RUN = 1;
    localparam int CTRL_PANEL_RST = 2;
    localparam int CTRL_SAVE = 3;
    // Reset values and AXI response codes
    localparam logic [3:0] CF_SHTD_RST = 4'h0;
    localparam logic [31:0] NOMINAL_RST = 32'h01E0_003C;
    localparam logic [31:0] OIL_RST = 32'h0000_0000;
    localparam logic [11:0] NORMAL_RPM_RST = 12'd1800;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Input indices
    localparam int IN_RSTART = 0;
    localparam int IN_LOWFUEL = 1;
    localparam int IN_CF0 = 2;
    localparam int IN_FRESET = 6;
    localparam int IN_IDLE = 7;
    localparam int IN_ESTOP = 8;
    localparam int IN_SPARE = 9;
endpackage
`default_nettype wire

// file: tb/field_contacts.sv
`default_nettype none
module field_contacts
(
    input wire logic [8:0] gnd, // Contacts closed to ground
    output logic [8:0] pins_b // Pulled-up contact lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] chg;
    initial pins_b = '1;
    // Real switches chatter, so every change bounces
    always @(gnd)
    begin
        chg = pins_b ^ ~gnd;
        repeat (4)
        begin
            #9 pins_b = pins_b ^ chg;
        end
        pins_b = ~gnd;
    end
endmodule
`default_nettype wire

// file: tb/genset_customer_io_logic_test.sv
`default_nettype none
module genset_customer_io_logic_test import custio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, overload = 0, underFreq = 0, runPilot = 0;
    logic [15:0] measVolts = 0, measFreq = 0, oilPressure = 0;
    logic [8:0] gnd = 0, pins_b;
    logic crankStart, wake, breakerTrip, commonAlarm, loadDump;
    logic readyToLoad, switchedSupply, inhibitBuildup, shutdown;
    logic [11:0] speedTarget;
    logic [2:0] msgSel;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int mismatches = 0, comparisons = 0, mWarn = 0, mShtd = 0;
    genset_customer_io_logic #(.LOAD_DUMP_CYCLES(32'd20)) uut
    (
        .mclk, .rst_b, .remoteStart_b(pins_b[IN_RSTART]),
        .lowFuel_b(pins_b[IN_LOWFUEL]), .custFault_b(pins_b[5:2]),
        .faultReset_b(pins_b[IN_FRESET]), .engineIdle_b(pins_b[IN_IDLE]),
        .eStop_b(pins_b[IN_ESTOP]), .overload, .underFreq, .measVolts,
        .measFreq, .runPilot, .oilPressure, .crankStart, .wake,
        .breakerTrip, .commonAlarm, .loadDump, .readyToLoad,
        .switchedSupply, .inhibitBuildup, .speedTarget, .msgSel, .shutdown,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    field_contacts fc (.gnd, .pins_b);
    always #2 mclk = ~mclk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ck(string s, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic hang();
        mismatches++;
        finish_test();
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic aw, w, b;
        logic [1:0] r;
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        b = 0;
        for (n = 0; n < 50 && !b; n++)
        begin
            @(negedge mclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 0;
        if (!b) hang();
        ck("bresp", RESP_OKAY, r);
    endtask
    task automatic rdr(logic [7:0] a);
        logic ar, v;
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        v = 0;
        for (n = 0; n < 50 && !v; n++)
        begin
            @(negedge mclk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge mclk);
            if (ar) s_axi_arvalid <= 0;
        end
        s_axi_rready <= 0;
        if (!v) hang();
    endtask
    // Waits out sync plus debounce latency
    task automatic pin(int i, logic v);
        @(posedge mclk);
        gnd[i] <= v;
        repeat (2600) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic st(string s);
        // Relays trail the fault latches by one register stage
        repeat (3) @(negedge mclk);
        ck({s, " alarm"}, mWarn | mShtd, commonAlarm);
        ck({s, " shut"}, mShtd, shutdown);
        ck({s, " trip"}, mShtd, breakerTrip);
        $display("test done: %s", s);
    endtask
    task automatic freset();
        pin(IN_FRESET, 1);
        pin(IN_FRESET, 0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int n;
        void'($urandom(28));
        repeat (3) @(posedge mclk);
        rst_b <= 1;
        @(negedge mclk);
        ck("rpm", NORMAL_RPM_RST, speedTarget);
        rdr(REG_NOMINAL);
        ck("nominal", NOMINAL_RST, rd);
        rdr(8'h40);
        ck("unmapped", RESP_SLVERR, rs);
        st("reset");
        for (int k = 0; k < 8; k++)
        begin
            @(posedge mclk);
            measVolts <= 16'($urandom_range(120));
            measFreq <= 16'($urandom_range(960));
            runPilot <= k[0];
            oilPressure <= 16'($urandom);
            repeat (4) @(negedge mclk);
            ck("ready", measVolts * 100 > NOMINAL_RST[15:0] * 90 &&
                measFreq * 100 > NOMINAL_RST[31:16] * 90, readyToLoad);
            ck("supply", runPilot, switchedSupply);
        end
        @(posedge mclk);
        runPilot <= 0;
        wr(REG_CTRL, 32'h0000_0001);
        pin(IN_RSTART, 1);
        ck("crank", 1, crankStart);
        pin(IN_LOWFUEL, 1);
        mWarn = 1;
        ck("wake fuel", 1, wake);
        st("low fuel");
        pin(IN_LOWFUEL, 0);
        pin(IN_CF0 + 1, 1);
        ck("wake cf2", 1, wake);
        ck("msg2", 2, msgSel);
        st("fault warn");
        pin(IN_CF0 + 1, 0);
        wr(REG_CFG, 32'h0000_0001);
        wr(REG_CTRL, 32'h0000_0009);
        rdr(REG_CFG);
        ck("cfg", 32'h0000_0011, rd);
        pin(IN_CF0, 1);
        mShtd = 1;
        ck("msg1", 1, msgSel);
        st("fault shut");
        pin(IN_CF0, 0);
        freset();
        st("start held");
        pin(IN_RSTART, 0);
        freset();
        mWarn = 0;
        mShtd = 0;
        st("fault reset");
        pin(IN_ESTOP, 1);
        mShtd = 1;
        pin(IN_ESTOP, 0);
        freset();
        st("estop held");
        wr(REG_CTRL, 32'h0000_0005);
        mShtd = 0;
        st("panel reset");
        wr(REG_OILNORM, 32'h0020_0030);
        wr(REG_OILIDLE, 32'h0008_0010);
        wr(REG_CTRL, 32'h0000_0002);
        pin(IN_IDLE, 1);
        ck("idle rpm", IDLE_RPM, speedTarget);
        ck("inhibit", 1, inhibitBuildup);
        rdr(REG_OILTRIP);
        ck("oil idle", 32'h0008_0010, rd);
        pin(IN_IDLE, 0);
        ck("run rpm", NORMAL_RPM_RST, speedTarget);
        ck("build", 0, inhibitBuildup);
        rdr(REG_OILTRIP);
        ck("oil norm", 32'h0020_0030, rd);
        wr(REG_CTRL, 32'h0000_0001);
        pin(IN_IDLE, 1);
        ck("auto rpm", NORMAL_RPM_RST, speedTarget);
        st("idle");
        pin(IN_IDLE, 0);
        @(posedge mclk);
        overload <= 1;
        repeat (15) @(posedge mclk);
        overload <= 0;
        @(posedge mclk);
        underFreq <= 1;
        repeat (15) @(negedge mclk);
        ck("dump early", 0, loadDump);
        for (n = 0; n < 30 && loadDump !== 1; n++) @(negedge mclk);
        ck("dump", 1, loadDump);
        ck("dump first", 0, shutdown);
        @(posedge mclk);
        underFreq <= 0;
        mShtd = 1;
        st("load dump");
        finish_test();
    end
endmodule
`default_nettype wire
